// File: logic/rops_pkg.sv
// Shared constants and types of the retriggerable one-shot pulser
package rops_pkg;
  localparam int CNT_W = 22;
  localparam int FILT_W = 16;
  localparam int STARTUP_TICKS = 500;
  localparam int RECOVERY_TICKS = 1;
  localparam int FILTER_TICKS_PER_STEP = 8;
  localparam logic [3:0] CODE_RESET = 4'h0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [31:0] ADDR_CFG = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam int CFG_CODE_LSB = 0;
  localparam int CFG_OVR_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_START = 2'h0,
    ST_IDLE = 2'h1,
    ST_ACTIVE = 2'h3,
    ST_RECOVER = 2'h2
  } rops_state_e;

  typedef struct packed {
    logic out_level;
    logic ready;
    logic active;
    logic invert;
    logic [3:0] code;
  } rops_status_s;

  typedef struct packed {
    logic [2:0] spare;
    logic use_sw_code;
    logic [3:0] sw_code;
  } rops_cfg_s;
endpackage

// File: logic/rops_pulser.sv
// One-shot pulse generator core with AXI4-Lite configuration and status
//
// Notes on behaviour
// RULE1 - Accepted launch edge makes output active and starts timing.
// RULE2 - After the programmed duration the output returns to idle.
// RULE3 - Eight prescale ratios: 1, 8, 64, 512, 4096, 2^15, 2^18, 2^21.
// RULE4 - Pulse lasts ratio times one master tick period.
// RULE5 - A 4-bit code selects both ratio and output inversion.
// RULE6 - Codes 0..7 ascend through ratios; codes 8..15 mirror them.
// RULE7 - Code MSB inverts output: active-low pulses, high idle.
// RULE8 - Non-retriggerable: edges ignored during pulse and short recovery.
// RULE9 - Retriggerable: each edge restarts timing during a pulse.
// RULE10 - Build options: rising or falling edge, retrigger on or off.
// RULE11 - Code changes accepted only after filter sees them stable.
// RULE12 - Acceptance delay grows with code difference, counted in ticks.
// RULE13 - Mid-pulse code change may give in-between width; later use new.
// RULE14 - During start-up output stays low and no pulse is made.
// RULE15 - Start-up lasts 500 master ticks regardless of ratio.
// RULE16 - Start-up end latches code, sets idle level, arms launch.
// RULE17 - Tick counter cleared on accepted edge, ends at ratio.
// RULE18 - Launch input synchronised and edge detected by sample compare.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rops_pulser #(
  parameter bit RISING_EDGE = 1'b1,
  parameter bit RETRIGGER = 1'b0,
  parameter int STARTUP_TICKS = rops_pkg::STARTUP_TICKS,
  parameter int RECOVERY_TICKS = rops_pkg::RECOVERY_TICKS,
  parameter int FILTER_TICKS_PER_STEP = rops_pkg::FILTER_TICKS_PER_STEP
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic master_tick,
  input wire logic launch_input,
  input wire logic [3:0] ratio_polarity_code,
  output logic pulse_out,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CW = rops_pkg::CNT_W;
  localparam int FW = rops_pkg::FILT_W;

  // Ratio 8^idx; upper half of the code space runs the table backwards
  function automatic logic [CW-1:0] ratio_of(input logic [3:0] code);
    logic [2:0] idx;
    idx = code[3] ? ~code[2:0] : code[2:0]; // RULE6
    ratio_of = CW'(1) << (3 * idx); // RULE3
  endfunction

  function automatic logic [FW-1:0] filter_len(input logic [3:0] a, input logic [3:0] b);
    logic [3:0] d;
    d = (a > b) ? (a - b) : (b - a);
    filter_len = FW'(int'(d) * FILTER_TICKS_PER_STEP); // RULE12
  endfunction

  // Launch synchroniser and edge detect
  logic sync_a;
  logic sync_b;
  logic sync_prev;
  logic launch_edge;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_prev <= 1'b0;
    end
    else
    begin
      sync_a <= launch_input; // RULE18
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end
  assign launch_edge = RISING_EDGE ? (sync_b & ~sync_prev) : (~sync_b & sync_prev); // RULE10

  // Configuration register
  rops_pkg::rops_cfg_s cfg;
  rops_pkg::rops_cfg_s next_cfg;
  logic [3:0] raw_code;
  assign raw_code = cfg.use_sw_code ? cfg.sw_code : ratio_polarity_code;

  // Code filter and core timer
  rops_pkg::rops_state_e state;
  rops_pkg::rops_state_e next_state;
  logic [3:0] applied;
  logic [3:0] next_applied;
  logic [3:0] cand;
  logic [3:0] next_cand;
  logic [FW-1:0] stable_cnt;
  logic [FW-1:0] next_stable_cnt;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_pulse_out;
  logic [CW-1:0] cur_ratio;
  assign cur_ratio = ratio_of(applied); // RULE5

  always_comb
  begin
    next_state = state;
    next_applied = applied;
    next_cand = cand;
    next_stable_cnt = stable_cnt;
    next_cnt = cnt;
    // Filter runs only after start-up; holds the old code until the new one stays stable for filter_len ticks
    if (state != rops_pkg::ST_START)
    begin
      if (raw_code != cand)
      begin
        next_cand = raw_code; // RULE11
        next_stable_cnt = '0;
      end
      else if (cand != applied)
      begin
        if (stable_cnt >= filter_len(cand, applied))
        begin
          next_applied = cand; // RULE11 RULE13
          next_stable_cnt = '0;
        end
        else if (master_tick)
        begin
          next_stable_cnt = stable_cnt + FW'(1);
        end
      end
      else
      begin
        next_stable_cnt = '0;
      end
    end
    case (state)
      rops_pkg::ST_START:
      begin
        if (master_tick)
        begin
          if (cnt + CW'(1) >= CW'(STARTUP_TICKS)) // RULE15
          begin
            next_applied = raw_code; // RULE16
            next_cand = raw_code;
            next_cnt = '0;
            next_state = rops_pkg::ST_IDLE;
          end
          else
          begin
            next_cnt = cnt + CW'(1);
          end
        end
      end
      rops_pkg::ST_IDLE:
      begin
        if (launch_edge)
        begin
          next_cnt = '0; // RULE17
          next_state = rops_pkg::ST_ACTIVE; // RULE1
        end
      end
      rops_pkg::ST_ACTIVE:
      begin
        if (RETRIGGER && launch_edge)
        begin
          next_cnt = '0; // RULE9
        end
        else if (master_tick)
        begin
          // Compare with >= so a smaller new ratio still ends the pulse
          if (cnt + CW'(1) >= cur_ratio) // RULE4 RULE13
          begin
            next_cnt = '0;
            next_state = RETRIGGER ? rops_pkg::ST_IDLE : rops_pkg::ST_RECOVER; // RULE2
          end
          else
          begin
            next_cnt = cnt + CW'(1);
          end
        end
      end
      rops_pkg::ST_RECOVER:
      begin
        // Edges here are dropped on purpose
        if (master_tick)
        begin
          if (cnt + CW'(1) >= CW'(RECOVERY_TICKS)) // RULE8
          begin
            next_cnt = '0;
            next_state = rops_pkg::ST_IDLE;
          end
          else
          begin
            next_cnt = cnt + CW'(1);
          end
        end
      end
      default:
      begin
        next_cnt = '0;
        next_state = rops_pkg::ST_START;
      end
    endcase
    if (next_state == rops_pkg::ST_START)
    begin
      next_pulse_out = 1'b0; // RULE14
    end
    else if (next_state == rops_pkg::ST_ACTIVE)
    begin
      next_pulse_out = ~next_applied[3]; // RULE7
    end
    else
    begin
      next_pulse_out = next_applied[3]; // RULE7 RULE16
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state <= rops_pkg::ST_START;
      applied <= rops_pkg::CODE_RESET;
      cand <= rops_pkg::CODE_RESET;
      stable_cnt <= '0;
      cnt <= '0;
      pulse_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      applied <= next_applied;
      cand <= next_cand;
      stable_cnt <= next_stable_cnt;
      cnt <= next_cnt;
      pulse_out <= next_pulse_out;
    end
  end

  // Status view
  rops_pkg::rops_status_s status;
  always_comb
  begin
    status.out_level = pulse_out;
    status.ready = (state != rops_pkg::ST_START);
    status.active = (state == rops_pkg::ST_ACTIVE);
    status.invert = applied[3];
    status.code = applied;
  end

  // AXI4-Lite slave, one write and one read at a time
  logic aw_held;
  logic w_held;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic next_aw_held;
  logic next_w_held;
  logic [31:0] next_awaddr_q;
  logic [31:0] next_wdata_q;
  logic [3:0] next_wstrb_q;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_cfg = cfg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = rops_pkg::RESP_OKAY;
      if (awaddr_q == rops_pkg::ADDR_CFG)
      begin
        if (wstrb_q[0])
        begin
          next_cfg = rops_pkg::rops_cfg_s'(wdata_q[7:0]);
        end
      end
      else if (awaddr_q != rops_pkg::ADDR_STATUS)
      begin
        // Status is read-only; writes there are dropped silently
        next_bresp = rops_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = rops_pkg::RESP_OKAY;
      if (s_axi_araddr == rops_pkg::ADDR_CFG)
      begin
        next_rdata = {24'h00_0000, cfg};
      end
      else if (s_axi_araddr == rops_pkg::ADDR_STATUS)
      begin
        next_rdata = {24'h00_0000, status};
      end
      else
      begin
        next_rdata = 32'h0000_0000;
        next_rresp = rops_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rops_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rops_pkg::RESP_OKAY;
      cfg <= rops_pkg::rops_cfg_s'(rops_pkg::CFG_RESET);
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      cfg <= next_cfg;
    end
  end
endmodule
`default_nettype wire

// File: tb/rops_launch_input_src.sv
// Trigger source model driving the launch input
`timescale 1ns/1ps
`default_nettype none
module rops_launch_input_src #(
  parameter bit IDLE = 1'b0
) (
  input wire logic clock,
  output logic launch_input
);
  initial launch_input = IDLE;
  // Level held four clocks so the synchroniser cannot miss it
  task automatic fire();
    repeat (4) @(posedge clock) launch_input <= ~IDLE;
    @(posedge clock) launch_input <= IDLE;
  endtask
endmodule
`default_nettype wire

// File: tb/rops_monitor.sv
// Port checker for the one-shot pulser
`timescale 1ns/1ps
`default_nettype none
module rops_monitor #(
  parameter int STARTUP_TICKS = 500,
  parameter bit RISING_EDGE = 1'b1,
  parameter bit RETRIGGER = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic master_tick,
  input wire logic launch_input,
  input wire logic [3:0] ratio_polarity_code,
  input wire logic pulse_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  int stc;
  int tcnt;
  int ratio;
  logic up;
  logic up_d;
  logic act;
  logic [2:0] idx;
  // Raw code stands in for applied code; bench also changes it outside reset and waits before firing
  assign idx = ratio_polarity_code[2:0] ^ {3{ratio_polarity_code[3]}};
  assign ratio = 1 << (3 * idx);
  assign up = stc >= STARTUP_TICKS;
  assign act = up && (pulse_out ^ ratio_polarity_code[3]);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      stc <= 0;
      tcnt <= 0;
      up_d <= 1'h0;
    end
    else
    begin
      stc <= up ? stc : stc + int'(master_tick);
      tcnt <= act ? tcnt + int'(master_tick) : 0;
      up_d <= up;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  rst_idle_a: assert property (disable iff (1'h0)
    sys_rst |=> !pulse_out && !s_axi_bvalid && !s_axi_rvalid) else $error("busy after reset");
  startup_low_a: assert property (!up |-> !pulse_out) else $error("early pulse");
  // Retriggered pulses outgrow one ratio by design; their width is judged by the bench
  width_cap_a: assert property (act && !RETRIGGER |-> tcnt < ratio)
    else $error("pulse too long");
  launch_cause_a: assert property (up_d && $rose(act) |->
    $past(launch_input, 2) == RISING_EDGE && $past(launch_input, 8) != RISING_EDGE)
    else $error("pulse without edge");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write answer");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready high");
  cover property ($rose(act));
  cover property (up && ratio_polarity_code[3]);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind rops_pulser rops_monitor #(
  .STARTUP_TICKS(STARTUP_TICKS),
  .RISING_EDGE(RISING_EDGE),
  .RETRIGGER(RETRIGGER)
) rops_monitor_inst (
  .clock, .sys_rst, .master_tick, .launch_input, .ratio_polarity_code, .pulse_out,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// File: tb/rops_pulser_tb_top.sv
// Self-checking bench for the one-shot pulser
`timescale 1ns/1ps
`default_nettype none
module rops_pulser_tb_top;
  localparam int SU = 40;
  localparam logic [31:0] CF = rops_pkg::ADDR_CFG;
  localparam logic [31:0] ST = rops_pkg::ADDR_STATUS;
  localparam logic [1:0] ERR = rops_pkg::RESP_SLVERR;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic master_tick = 1'h0;
  logic launch_input;
  logic pulse_out;
  logic launch_input_b;
  logic pulse_out_b;
  logic [3:0] ratio_polarity_code = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total = 0, cmp_count = 0, tper = 1, tdiv = 0, tmo = 0;
  rops_pulser #(.STARTUP_TICKS(SU)) rops_pulser_inst (
    .clock, .sys_rst, .master_tick, .launch_input, .ratio_polarity_code, .pulse_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  rops_launch_input_src rops_launch_input_src_inst (.clock, .launch_input);
  // Second build option: falling edge, retrigger allowed; bus left idle
  rops_pulser #(.STARTUP_TICKS(SU), .RISING_EDGE(1'b0), .RETRIGGER(1'b1)) rops_pulser_b_inst (
    .clock, .sys_rst, .master_tick, .launch_input(launch_input_b), .ratio_polarity_code,
    .pulse_out(pulse_out_b), .s_axi_awaddr(32'h0), .s_axi_awvalid(1'h0), .s_axi_awready(),
    .s_axi_wdata(32'h0), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'h0), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'h0), .s_axi_araddr(32'h0),
    .s_axi_arvalid(1'h0), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(1'h0)
  );
  rops_launch_input_src #(.IDLE(1'b1)) rops_launch_input_src_b_inst (.clock, .launch_input(launch_input_b));
  always #5 clock = ~clock;
  task automatic final_report();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Tick period is adjustable to show width scales with it
  always @(posedge clock)
  begin
    tdiv <= (tdiv + 1 >= tper) ? 0 : tdiv + 1;
    master_tick <= tdiv + 1 >= tper;
    tmo <= tmo + 1;
    if (tmo == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic [3:0] c);
    @(posedge clock);
    ratio_polarity_code <= c;
    sys_rst <= 1'h1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'h0;
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Counts cycles away from idle; a second edge 20 clocks in when asked
  task automatic pw(input bit again, input int win, output int w);
    logic idle;
    idle = pulse_out;
    w = 0;
    fork
      rops_launch_input_src_inst.fire();
      if (again)
      begin
        repeat (20) @(posedge clock);
        rops_launch_input_src_inst.fire();
      end
      repeat (win)
      begin
        @(posedge clock);
        w += int'(pulse_out !== idle);
      end
    join
  endtask
  task automatic t_boot();
    logic [31:0] d;
    logic [1:0] r;
    rst(4'h0);
    axr(ST, d, r);
    chk(d[7:6], 2'h0);
    repeat (SU + 10) @(posedge clock);
    axr(ST, d, r);
    chk(d, 32'h40);
    axr(CF, d, r);
    chk(d, 32'h0);
    axw(CF, 32'h3, r);
    axr(CF, d, r);
    chk(d, 32'h3);
    axw(CF, 32'h0, r);
    axw(32'h8, 32'h1, r);
    chk(r, ERR);
    axr(32'h8, d, r);
    chk({r, d}, {ERR, 32'h0});
    axw(ST, 32'hFF, r);
    chk(r, rops_pkg::RESP_OKAY);
  endtask
  task automatic t_width();
    int w;
    int r;
    for (int i = 0; i < 4; i++)
    begin
      tper <= 1 + i % 2;
      ratio_polarity_code <= 4'(i);
      repeat (60) @(posedge clock);
      r = (1 << (3 * i)) * tper;
      pw(0, r + 30, w);
      chk(w > r - tper && w <= r + 1, 1'h1);
    end
  endtask
  task automatic t_once();
    int w;
    tper <= 1;
    repeat (10) @(posedge clock);
    pw(1, 560, w);
    chk(w > 511 && w <= 513, 1'h1);
  endtask
  // Second falling edge 20 clocks in stretches the pulse to 20 plus one ratio
  task automatic t_retrig();
    int w;
    w = 0;
    fork
      rops_launch_input_src_b_inst.fire();
      begin
        repeat (20) @(posedge clock);
        rops_launch_input_src_b_inst.fire();
      end
      repeat (560)
      begin
        @(posedge clock);
        w += int'(pulse_out_b !== 1'h0);
      end
    join
    chk(w > 531 && w <= 533, 1'h1);
  endtask
  task automatic t_filter();
    logic [31:0] d;
    logic [1:0] r;
    ratio_polarity_code <= 4'h6;
    axr(ST, d, r);
    chk(d[3:0], 4'h3);
    repeat (12) @(posedge clock);
    axr(ST, d, r);
    chk(d[3:0], 4'h3);
    repeat (30) @(posedge clock);
    axr(ST, d, r);
    chk(d[3:0], 4'h6);
    axw(CF, 32'h15, r);
    repeat (20) @(posedge clock);
    axr(ST, d, r);
    chk(d[4:0], 5'h05);
    axw(CF, 32'h0, r);
  endtask
  task automatic t_pol();
    logic [31:0] d;
    logic [1:0] r;
    int w;
    rst(4'hE);
    repeat (10) @(posedge clock);
    chk(pulse_out, 1'h0);
    repeat (SU + 10) @(posedge clock);
    chk(pulse_out, 1'h1);
    axr(ST, d, r);
    chk(d, 32'hDE);
    pw(0, 40, w);
    chk(w > 7 && w <= 9, 1'h1);
  endtask
  initial
  begin
    t_boot();
    t_width();
    t_once();
    t_retrig();
    t_filter();
    t_pol();
    final_report();
  end
endmodule
`default_nettype wire
